/* design/srw_supervisor.v */
/*
 supply reset generator and timeout/window watchdog with blanking.
 assumes select inputs synchronous to clk_sys_i (kick and power good are synchronised); power_good_i stands for the
 output-voltage comparison; active-low outputs are open-drain style.
*/
// Contract
// - supply reset low while output is below 90 percent of target.
// - supply reset held low through power-up, power-down and brownout.
// - on supply good, run reset timer, then release supply reset.
// - supply falling below threshold drives supply reset low and holds it.
// - supply-good comparison integrated so short dips change nothing.
// - timeout mode faults when no kick edge of either sense in upper period.
// - window mode counts only falling kick edges.
// - window mode faults on more than two kicks inside lower period.
// - window mode faults when no falling kick in upper period.
// - kicks ignored during blanking after either output rises.
// - upper period is 31 times lower period, both from one setting.
// - fault starts reset timer, kicks ignored, fault released on expiry.
// - fault and supply reset never low together; supply reset wins.
// - watchdog off when off-select high, on when low.
// - mode select low is window mode, high is timeout mode.
// - reset timeout set by reset period setting, valid from 5 ms.
// - upper period set by watchdog period setting, valid from 20 ms.
// - lower period scaling accurate only from 3 ms.
// - first kick after blanking has no lower bound, only upper.
// - watchdog fault restarts reset timer, supply reset stays high.
`timescale 1ns/1ps
`include "srw_consts.vh"

module srw_supervisor #(
   parameter CW = 28,
   parameter [CW-1:0] RESET_CYCLES = `SRW_RESET_CYCLES,
   parameter [CW-1:0] UPPER_CYCLES = `SRW_UPPER_CYCLES,
   parameter [CW-1:0] BLANK_CYCLES = `SRW_BLANK_CYCLES,
   parameter [CW-1:0] FILTER_CYCLES = `SRW_FILTER_CYCLES
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire power_good_i,
   input wire kick_input_i,
   input wire watchdog_off_sel_i,
   input wire timeout_mode_sel_i,
   output reg supply_reset_n_o,
   output reg supply_reset_n_oe_o,
   output reg watchdog_fault_n_o,
   output reg watchdog_fault_n_oe_o
);

   // derived periods and constants, at counter width except 2-bit MAX_FAST
   localparam [CW-1:0] RATIO = `SRW_UPPER_LOWER_RATIO;
   localparam [CW-1:0] LOWER_CYCLES = UPPER_CYCLES / RATIO;
   localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
   localparam [CW-1:0] ZERO = {CW{1'b0}};
   localparam [CW-1:0] RESET_LAST = RESET_CYCLES - ONE;
   localparam [CW-1:0] BLANK_LAST = BLANK_CYCLES - ONE;
   localparam [CW-1:0] UPPER_LAST = UPPER_CYCLES - ONE;
   localparam [CW-1:0] FILTER_LAST = FILTER_CYCLES - ONE;
   localparam [1:0] MAX_FAST = `SRW_MAX_FAST_KICKS;

   // one-hot states
   localparam [4:0] ST_SUPPLY = 5'h01;
   localparam [4:0] ST_RESET = 5'h02;
   localparam [4:0] ST_BLANK = 5'h04;
   localparam [4:0] ST_WATCH = 5'h08;
   localparam [4:0] ST_FAULT = 5'h10;

   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [CW-1:0] tmr_q;
   reg [CW-1:0] tmr_d;
   reg [CW-1:0] win_q;
   reg [CW-1:0] win_d;
   reg [CW-1:0] filt_q;
   reg [CW-1:0] filt_d;
   reg good_q;
   reg good_d;
   reg [1:0] fast_q;
   reg [1:0] fast_d;
   reg first_q;
   reg first_d;
   reg kick_s1_q;
   reg kick_s2_q;
   reg kick_s3_q;
   reg pg_s1_q;
   reg pg_s2_q;
   reg srst_n_d;
   reg wdf_n_d;
   wire kick_rise;
   wire kick_fall;
   wire kick_evt;
   wire pg_differs;
   wire filt_full;
   wire filt_idle;
   wire reset_done;
   wire blank_done;
   wire upper_done;
   wire lower_open;
   wire kick_valid;
   wire kick_too_fast;

   // kick edges; window mode honours only falling edges
   assign kick_rise = kick_s2_q & ~kick_s3_q;
   assign kick_fall = ~kick_s2_q & kick_s3_q;
   assign kick_evt = timeout_mode_sel_i ? (kick_rise | kick_fall) : kick_fall;

   // decoded timer and window conditions
   assign pg_differs = (pg_s2_q != good_q);
   assign filt_full = (filt_q >= FILTER_LAST);
   assign filt_idle = (filt_q == ZERO);
   assign reset_done = (tmr_q >= RESET_LAST);
   assign blank_done = (tmr_q >= BLANK_LAST);
   assign upper_done = (tmr_q >= UPPER_LAST);
   assign lower_open = (win_q >= LOWER_CYCLES);
   assign kick_valid = timeout_mode_sel_i | first_q | lower_open;
   assign kick_too_fast = (fast_q >= MAX_FAST);

   // kick synchroniser, idles high
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         kick_s1_q <= 1'b1;
         kick_s2_q <= 1'b1;
      end else begin
         kick_s1_q <= kick_input_i;
         kick_s2_q <= kick_s1_q;
      end
   end

   // kick edge history
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         kick_s3_q <= 1'b1;
      end else begin
         kick_s3_q <= kick_s2_q;
      end
   end

   // power-good synchroniser
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pg_s1_q <= 1'b0;
         pg_s2_q <= 1'b0;
      end else begin
         pg_s1_q <= power_good_i;
         pg_s2_q <= pg_s1_q;
      end
   end

   // integrating filter on supply good
   always @* begin
      filt_d = filt_q;
      good_d = good_q;
      if (pg_differs) begin
         if (filt_full) begin
            good_d = pg_s2_q;
            filt_d = ZERO;
         end else begin
            filt_d = filt_q + ONE;
         end
      end else if (!filt_idle) begin
         filt_d = filt_q - ONE;
      end
   end

   // main sequencer
   always @* begin
      state_d = state_q;
      tmr_d = tmr_q;
      win_d = win_q;
      fast_d = fast_q;
      first_d = first_q;
      srst_n_d = supply_reset_n_o;
      wdf_n_d = watchdog_fault_n_o;
      if (!good_q) begin
         state_d = ST_SUPPLY;
         srst_n_d = 1'b0;
         wdf_n_d = 1'b1;
         tmr_d = {CW{1'b0}};
      end else begin
         case (state_q)
            // supply just became good
            ST_SUPPLY: begin
               state_d = ST_RESET;
               tmr_d = {CW{1'b0}};
            end
            // reset timer running
            ST_RESET: begin
               if (reset_done) begin
                  srst_n_d = 1'b1;
                  wdf_n_d = 1'b1;
                  state_d = ST_BLANK;
                  tmr_d = {CW{1'b0}};
               end else begin
                  tmr_d = tmr_q + ONE;
               end
            end
            ST_BLANK: begin
               // kicks ignored here
               if (blank_done) begin
                  state_d = ST_WATCH;
                  tmr_d = {CW{1'b0}};
                  win_d = {CW{1'b0}};
                  fast_d = 2'h0;
                  first_d = 1'b1;
               end else begin
                  tmr_d = tmr_q + ONE;
               end
            end
            // watching kick edges
            ST_WATCH: begin
               tmr_d = tmr_q + ONE;
               win_d = lower_open ? win_q : win_q + ONE;
               if (watchdog_off_sel_i) begin
                  tmr_d = {CW{1'b0}};
                  first_d = 1'b1;
               end else if (kick_evt) begin
                  tmr_d = {CW{1'b0}};
                  first_d = 1'b0;
                  if (kick_valid) begin
                     win_d = {CW{1'b0}};
                     fast_d = 2'h1;
                  end else if (kick_too_fast) begin
                     state_d = ST_FAULT;
                  end else begin
                     fast_d = fast_q + 2'h1;
                  end
               end else if (upper_done) begin
                  state_d = ST_FAULT;
               end
               if (state_d == ST_FAULT) begin
                  wdf_n_d = 1'b0;
                  tmr_d = {CW{1'b0}};
               end
            end
            // one fault cycle, then reset timer
            ST_FAULT: begin
               state_d = ST_RESET;
               tmr_d = ONE;
            end
            default: begin
               state_d = ST_SUPPLY;
               srst_n_d = 1'b0;
               wdf_n_d = 1'b1;
            end
         endcase
      end
   end

   // sequencer state and timer
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_SUPPLY;
         tmr_q <= ZERO;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
      end
   end

   // window bookkeeping
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         win_q <= ZERO;
         fast_q <= 2'h0;
         first_q <= 1'b1;
      end else begin
         win_q <= win_d;
         fast_q <= fast_d;
         first_q <= first_d;
      end
   end

   // supply-good integrator
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         filt_q <= ZERO;
         good_q <= 1'b0;
      end else begin
         filt_q <= filt_d;
         good_q <= good_d;
      end
   end

   // supply reset output stage, driven low or released
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         supply_reset_n_o <= 1'b0;
         supply_reset_n_oe_o <= 1'b1;
      end else begin
         supply_reset_n_o <= srst_n_d;
         supply_reset_n_oe_o <= ~srst_n_d;
      end
   end

   // watchdog fault output stage, driven low or released
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         watchdog_fault_n_o <= 1'b1;
         watchdog_fault_n_oe_o <= 1'b0;
      end else begin
         watchdog_fault_n_o <= wdf_n_d;
         watchdog_fault_n_oe_o <= ~wdf_n_d;
      end
   end

endmodule // srw_supervisor

/* pkg/srw_consts.vh */
/*
 header of timing constants for the supply reset and
 window watchdog supervisor. assumes a 250 MHz system clock.
*/
`ifndef SRW_CONSTS_VH
`define SRW_CONSTS_VH

`define SRW_CLK_MHZ 250
// reset timeout in microseconds (5 ms, smallest accurate programmed value)
`define SRW_RESET_PERIOD_US 5000
// upper boundary in microseconds (20 ms)
`define SRW_UPPER_PERIOD_US 20000
// ratio upper to lower boundary
`define SRW_UPPER_LOWER_RATIO 31
// blanking time in microseconds (capacitor ramp to 200mV)
`define SRW_BLANK_PERIOD_US 200
// supply-good integration time in microseconds
`define SRW_FILTER_PERIOD_US 10
// kick pulses allowed inside lower boundary in window mode
`define SRW_MAX_FAST_KICKS 2
// cycle counts
`define SRW_RESET_CYCLES (`SRW_RESET_PERIOD_US * `SRW_CLK_MHZ)
`define SRW_UPPER_CYCLES (`SRW_UPPER_PERIOD_US * `SRW_CLK_MHZ)
`define SRW_BLANK_CYCLES (`SRW_BLANK_PERIOD_US * `SRW_CLK_MHZ)
`define SRW_FILTER_CYCLES (`SRW_FILTER_PERIOD_US * `SRW_CLK_MHZ)

`endif

/* testbench/srw_supervisor_monitor.sv */
/* checker on the supervisor ports; bound from the bench top file */
`timescale 1ns/1ps
module srw_supervisor_monitor #(
   parameter integer RESET_CYCLES = 40
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire power_good_i,
   input wire watchdog_off_sel_i,
   input wire supply_reset_n_o,
   input wire supply_reset_n_oe_o,
   input wire watchdog_fault_n_o,
   input wire watchdog_fault_n_oe_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_reset_oe_tracks: assert property (supply_reset_n_oe_o == !supply_reset_n_o)
      else $error("reset enable differs");
   a_fault_oe_tracks: assert property (watchdog_fault_n_oe_o == !watchdog_fault_n_o)
      else $error("fault enable differs");
   a_never_both_low: assert property (supply_reset_n_o || watchdog_fault_n_o)
      else $error("both outputs low");
   a_boot_hold_low: assert property ($fell(rst_i) |-> (!supply_reset_n_o)[*8])
      else $error("reset released early");
   a_bad_supply_low: assert property ((!power_good_i)[*8] |-> ##1 !supply_reset_n_o)
      else $error("reset not low on bad supply");
   a_release_after_timer: assert property ($rose(supply_reset_n_o) |->
      $past(power_good_i, RESET_CYCLES)) else $error("reset released early");
   a_fault_needs_on: assert property ($fell(watchdog_fault_n_o) |->
      !$past(watchdog_off_sel_i, 4)) else $error("fault while disabled");
   a_fault_min_low: assert property ($fell(watchdog_fault_n_o) |-> (!watchdog_fault_n_o)[*8])
      else $error("fault too short");
   a_fault_ends_timer: assert property ($fell(watchdog_fault_n_o) |-> ##[30:60] watchdog_fault_n_o)
      else $error("fault not released");
   a_fault_keeps_rst: assert property ($fell(watchdog_fault_n_o) |-> supply_reset_n_o[*8])
      else $error("reset dropped on fault");
   c_fault: cover property ($fell(watchdog_fault_n_o));
   c_release: cover property ($rose(supply_reset_n_o));
   c_fault_end: cover property ($rose(watchdog_fault_n_o));
endmodule // srw_supervisor_monitor

/* testbench/srw_kick_model.sv */
/* processor stand-in: toggles the kick line every gap+1 cycles while
   enabled; idles high as the pulled-up line does */
`timescale 1ns/1ps
module srw_kick_model (
   input wire clk_i,
   input wire en_i,
   input wire [9:0] gap_i,
   output reg kick_o
);
   reg [9:0] cnt_q = 10'h000;
   initial kick_o = 1'b1;
   always @(negedge clk_i) begin
      if (!en_i) begin
         kick_o <= 1'b1;
         cnt_q <= 10'h000;
      end else if (cnt_q >= gap_i) begin
         kick_o <= !kick_o;
         cnt_q <= 10'h000;
      end else begin
         cnt_q <= cnt_q + 10'h001;
      end
   end
endmodule // srw_kick_model

/* testbench/srw_supervisor_tb.sv */
/* bench for the supervisor: table of watchdog runs, then supply cases;
   uses shortened period parameters */
`timescale 1ns/1ps
module srw_supervisor_tb;
   reg clk_sys_i = 1'b0;
   reg rst_i = 1'b1;
   reg pg = 1'b0;
   reg off = 1'b0;
   reg tmo = 1'b0;
   reg en = 1'b0;
   reg [9:0] gap = 10'h000;
   wire kick, sr, sr_oe, wf, wf_oe;
   integer fails = 0;
   integer tests_run = 0;
   integer i, n;
   reg low;
   reg [13:0] rows [0:6];
   srw_kick_model km (.clk_i(clk_sys_i), .en_i(en), .gap_i(gap), .kick_o(kick));
   srw_supervisor #(.RESET_CYCLES(28'h0000028), .UPPER_CYCLES(28'h0000136),
      .BLANK_CYCLES(28'h0000008), .FILTER_CYCLES(28'h0000004)) DUT (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .power_good_i(pg), .kick_input_i(kick), .watchdog_off_sel_i(off),
      .timeout_mode_sel_i(tmo), .supply_reset_n_o(sr), .supply_reset_n_oe_o(sr_oe),
      .watchdog_fault_n_o(wf), .watchdog_fault_n_oe_o(wf_oe));
   initial begin
      forever #2 clk_sys_i = !clk_sys_i;
   end
   task chk(input [95:0] nm, input e, input g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            $display("ERROR %0s expected %b seen %b", nm, e, g);
            fails = fails + 1;
         end
      end
   endtask
   task boot;
      begin
         rst_i = 1'b1;
         pg = 1'b1;
         repeat (3) @(negedge clk_sys_i);
         chk("rst_hold", 1'b0, sr);
         chk("wdog_idle", 1'b1, wf);
         rst_i = 1'b0;
         n = 0;
         while (sr !== 1'b1 && n < 200) begin
            @(negedge clk_sys_i);
            n = n + 1;
         end
         chk("release", 1'b1, sr);
      end
   endtask
   task watch(input integer c, input s);
      begin
         low = 1'b0;
         repeat (c) @(negedge clk_sys_i) low = low | ((s ? sr : wf) !== 1'b1);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      #100000;
      fails = fails + 1;
      wrap_up;
   end
   initial begin
      rows[0] = {3'b001, 10'h014, 1'b0};
      rows[1] = {3'b010, 10'h000, 1'b0};
      rows[2] = {3'b000, 10'h000, 1'b1};
      rows[3] = {3'b101, 10'h0C8, 1'b0};
      rows[4] = {3'b001, 10'h0C8, 1'b1};
      rows[5] = {3'b001, 10'h001, 1'b1};
      rows[6] = {3'b100, 10'h000, 1'b1};
      for (i = 0; i < 7; i = i + 1) begin
         tmo = rows[i][13];
         off = rows[i][12];
         gap = rows[i][10:1];
         boot;
         en = rows[i][11];
         watch(1000, 1'b0);
         chk("fault", rows[i][0], low);
         en = 1'b0;
      end
      tmo = 1'b0;
      off = 1'b0;
      boot;
      pg = 1'b0;
      @(negedge clk_sys_i);
      pg = 1'b1;
      watch(20, 1'b1);
      chk("dip", 1'b0, low);
      n = 0;
      while (wf !== 1'b0 && n < 600) begin
         @(negedge clk_sys_i);
         n = n + 1;
      end
      repeat (10) @(negedge clk_sys_i);
      chk("fault_low", 1'b0, wf);
      chk("rst_kept", 1'b1, sr);
      pg = 1'b0;
      repeat (20) @(negedge clk_sys_i);
      chk("brownout", 1'b0, sr);
      chk("fault_clr", 1'b1, wf);
      wrap_up;
   end
endmodule // srw_supervisor_tb
bind srw_supervisor srw_supervisor_monitor #(.RESET_CYCLES(RESET_CYCLES)) mon (.clk_sys_i(clk_sys_i),
   .rst_i(rst_i), .power_good_i(power_good_i), .watchdog_off_sel_i(watchdog_off_sel_i),
   .supply_reset_n_o(supply_reset_n_o), .supply_reset_n_oe_o(supply_reset_n_oe_o),
   .watchdog_fault_n_o(watchdog_fault_n_o), .watchdog_fault_n_oe_o(watchdog_fault_n_oe_o));
